// ==== rtl/iorrd_pkg.sv ====
/*
  Shared constants of the riser reset distribution block: clock rate,
  standby release delay, fan-out width and supervisor states.
  Assumes one 100 MHz clock and inputs already synchronous to it.
*/
// How it works
// - The standby supervisor waits a fixed delay after the standby rail nears 3 V, then releases the active-low standby good reset.
// - The incoming main power ok is forwarded as our own main power ok to the south bridge hub.
// - The hub bus reset is buffered into exact copies for super I/O, controller bus port and firmware hub; video and Ethernet get merged versions.
// - The hub resume well and the controller core take only the standby good reset, never the bus reset.
// - The super I/O copy of the bus reset resets both its bus interface and its core.
// - Video reset asserts while the bus reset is active or while the controller sets its video reset request bit to one.
// - Ethernet is reset by standby good after each standby power-on or reprogram pulse and, once main power ok has been seen again, also by the buffered bus reset.
// - This logic is held in reset by standby good while standby settles and again by the reprogram reset pulse.
`default_nettype none
package iorrd_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned STBY_DELAY_MS = 150;
  localparam int unsigned STBY_DELAY_CYC = STBY_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned STBY_CNT_W = 24;
  localparam int unsigned BUS_RST_FANOUT = 11;
  localparam int unsigned MAIN_CLK_STABLE_US = 1000;

  typedef enum logic [1:0] {
    IORRD_SUP_WAIT_RAIL = 2'h0,
    IORRD_SUP_DELAY = 2'h1,
    IORRD_SUP_GOOD = 2'h3
  } iorrd_sup_state_t;
endpackage
`default_nettype wire

// ==== rtl/iorrd_reset_dist.sv ====
/*
  Riser reset distribution: standby supervisor, main power ok
  forwarding, fan-out of the hub bus reset, video and Ethernet reset
  merging, and the block's own reset from standby good and reprogram.
  Standby-domain resets come straight from the supervisor; every
  main-domain reset other than Ethernet, and the forwarded power ok, leave through a flop,
  one edge behind the inputs that make them.
  While this logic is in its own reset every one of those outputs is
  low, so the devices behind it stay held until standby is good.
  Assumes all inputs synchronous to ref_clk_i; resets are active low.
*/
`default_nettype none
module iorrd_reset_dist #(
  parameter int unsigned STBY_DELAY_CYC = iorrd_pkg::STBY_DELAY_CYC,
  parameter int unsigned FANOUT = iorrd_pkg::BUS_RST_FANOUT
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic stby_rail_near_thresh_i, // standby rail near 3 V
  input wire logic main_power_ok_i, // from board reset circuit
  input wire logic pci_bus_reset_low_i, // bus reset from hub, low active
  input wire logic logic_reprogram_reset_low_i, // controller reprogram reset
  input wire logic video_reset_req_i, // controller video reset request bit
  output logic standby_power_good_n_o, // standby good reset, low active
  output logic hub_resume_reset_n_o, // hub resume well reset
  output logic mgmt_core_reset_n_o, // controller core reset
  output logic main_power_ok_o, // forwarded to hub
  output logic video_reset_n_o, // video controller reset
  output logic super_io_reset_n_o, // super I/O bus and core reset
  output logic mgmt_lpc_reset_n_o, // controller bus port reset
  output logic firmware_hub_reset_n_o, // firmware hub reset
  output logic ethernet_reset_n_o, // Ethernet controller reset
  output logic [FANOUT-1:0] pci_reset_copy_n_o // remaining bus reset copies
);
  typedef struct packed {
    logic pwr_ok;
    logic main_seen;
    logic video_n;
    logic sio_n;
    logic lpc_n;
    logic fwh_n;
    logic eth_n;
    logic [FANOUT-1:0] copy_n;
  } iorrd_dist_t;

  localparam iorrd_dist_t DIST_RST = '{
    pwr_ok: 1'b0,
    main_seen: 1'b0,
    video_n: 1'b0,
    sio_n: 1'b0,
    lpc_n: 1'b0,
    fwh_n: 1'b0,
    eth_n: 1'b0,
    copy_n: '0
  };

  // how far the main-powered side has come, as seen from here
  typedef enum logic [1:0] {
    IORRD_PH_HELD = 2'h0,
    IORRD_PH_STBY = 2'h1,
    IORRD_PH_MAIN = 2'h3
  } iorrd_phase_t;

  function automatic logic own_reset_f(
    input logic good_n,
    input logic reprog_n
  );
    logic held;
    held = !good_n || !reprog_n;
    return held;
  endfunction

  function automatic logic bus_copy_f(
    input logic hub_n
  );
    logic copy_n;
    copy_n = hub_n;
    return copy_n;
  endfunction

  // a plain follower, so the forwarded level falls one edge after the
  // input falls and never later
  function automatic logic pwr_ok_f(
    input logic ok_in
  );
    logic fwd;
    fwd = ok_in;
    return fwd;
  endfunction

  // video is held by the bus reset or by the controller's request bit
  function automatic logic video_merge_f(
    input logic hub_n,
    input logic req
  );
    logic merged_n;
    merged_n = hub_n && !req;
    return merged_n;
  endfunction

  // until main power has been seen once the bus reset is ignored
  function automatic logic eth_merge_f(
    input logic hub_n,
    input logic main_seen
  );
    logic merged_n;
    merged_n = hub_n || !main_seen;
    return merged_n;
  endfunction

  function automatic iorrd_phase_t phase_f(
    input logic held,
    input logic main_seen
  );
    iorrd_phase_t ph;
    if (held) begin
      ph = IORRD_PH_HELD;
    end else if (main_seen) begin
      ph = IORRD_PH_MAIN;
    end else begin
      ph = IORRD_PH_STBY;
    end
    return ph;
  endfunction

  logic stby_good_n;
  logic own_reset;
  logic main_ok_in;
  logic hub_rst_n;
  logic reprog_n;
  logic video_req;
  logic [FANOUT-1:0] copy_d;
  iorrd_phase_t phase;
  iorrd_dist_t s_q;
  iorrd_dist_t s_d;

  iorrd_stby_supervisor #(
    .CNT_W(iorrd_pkg::STBY_CNT_W),
    .DELAY_CYC(STBY_DELAY_CYC)
  ) u_sup (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .rail_near_thresh_i(stby_rail_near_thresh_i),
    .standby_power_good_n_o(stby_good_n)
  );

  // plain renames of the pins so the logic below reads in one vocabulary
  assign main_ok_in = main_power_ok_i;
  assign hub_rst_n = pci_bus_reset_low_i;
  assign reprog_n = logic_reprogram_reset_low_i;
  assign video_req = video_reset_req_i;

  // held while standby settles and during a reprogram pulse
  assign own_reset = own_reset_f(stby_good_n, reprog_n);
  assign phase = phase_f(own_reset, s_q.main_seen);

  // every extra copy is a flop of its own, so one heavy load cannot
  // slow the edge that the other devices see
  for (genvar gi = 0; gi < FANOUT; gi++) begin : g_copy_d
    assign copy_d[gi] = bus_copy_f(hub_rst_n);
  end

  always_comb begin
    s_d = s_q;
    case (phase)
      IORRD_PH_HELD: begin
        s_d = DIST_RST;
      end
      IORRD_PH_STBY: begin
        // until main power ok has been seen since the last own reset the hub's bus reset only
        // reflects a dead main domain, so Ethernet follows standby alone
        s_d.pwr_ok = pwr_ok_f(main_ok_in);
        s_d.main_seen = main_ok_in;
        s_d.sio_n = bus_copy_f(hub_rst_n);
        s_d.lpc_n = bus_copy_f(hub_rst_n);
        s_d.fwh_n = bus_copy_f(hub_rst_n);
        s_d.copy_n = copy_d;
        s_d.video_n = video_merge_f(hub_rst_n, video_req);
        s_d.eth_n = eth_merge_f(hub_rst_n, 1'b0);
      end
      IORRD_PH_MAIN: begin
        // drops with the input; the hub sequences its own bus reset after
        s_d.pwr_ok = pwr_ok_f(main_ok_in);
        s_d.main_seen = 1'b1;
        s_d.sio_n = bus_copy_f(hub_rst_n);
        s_d.lpc_n = bus_copy_f(hub_rst_n);
        s_d.fwh_n = bus_copy_f(hub_rst_n);
        s_d.copy_n = copy_d;
        s_d.video_n = video_merge_f(hub_rst_n, video_req);
        s_d.eth_n = eth_merge_f(hub_rst_n, 1'b1);
      end
      default: begin
        s_d = DIST_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= DIST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // standby-domain resets never see the bus reset
  assign standby_power_good_n_o = stby_good_n;
  assign hub_resume_reset_n_o = stby_good_n;
  assign mgmt_core_reset_n_o = stby_good_n;

  // main-domain outputs come straight from flops
  assign main_power_ok_o = s_q.pwr_ok;
  assign video_reset_n_o = s_q.video_n;
  assign super_io_reset_n_o = s_q.sio_n;
  assign mgmt_lpc_reset_n_o = s_q.lpc_n;
  assign firmware_hub_reset_n_o = s_q.fwh_n;

  // gated by standby good too, so Ethernet is held from the very first edge
  assign ethernet_reset_n_o = s_q.eth_n && stby_good_n;
  for (genvar go = 0; go < FANOUT; go++) begin : g_copy_out
    assign pci_reset_copy_n_o[go] = s_q.copy_n[go];
  end
endmodule
`default_nettype wire

// ==== rtl/iorrd_stby_supervisor.sv ====
/*
  Standby supervisor: counts a fixed delay once the standby rail is
  near threshold, then releases the active-low standby good reset.
  Assumes the rail detector input is synchronous and already filtered.
*/
`default_nettype none
module iorrd_stby_supervisor #(
  parameter int unsigned CNT_W = iorrd_pkg::STBY_CNT_W,
  parameter int unsigned DELAY_CYC = iorrd_pkg::STBY_DELAY_CYC
) (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic rail_near_thresh_i, // standby rail above detect level
  output logic standby_power_good_n_o // low holds standby domain in reset
);
  typedef struct packed {
    iorrd_pkg::iorrd_sup_state_t st;
    logic [CNT_W-1:0] cnt;
    logic good;
  } iorrd_sup_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY_CYC - 1);

  iorrd_sup_t s_q;
  iorrd_sup_t s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      iorrd_pkg::IORRD_SUP_WAIT_RAIL: begin
        s_d.cnt = '0;
        s_d.good = 1'b0;
        if (rail_near_thresh_i) begin
          s_d.st = iorrd_pkg::IORRD_SUP_DELAY;
        end
      end
      iorrd_pkg::IORRD_SUP_DELAY: begin
        // a dip during the delay restarts the whole wait
        if (!rail_near_thresh_i) begin
          s_d.st = iorrd_pkg::IORRD_SUP_WAIT_RAIL;
          s_d.cnt = '0;
        end else if (s_q.cnt == LAST) begin
          s_d.st = iorrd_pkg::IORRD_SUP_GOOD;
          s_d.good = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      iorrd_pkg::IORRD_SUP_GOOD: begin
        if (!rail_near_thresh_i) begin
          s_d.st = iorrd_pkg::IORRD_SUP_WAIT_RAIL;
          s_d.good = 1'b0;
          s_d.cnt = '0;
        end
      end
      default: begin
        s_d.st = iorrd_pkg::IORRD_SUP_WAIT_RAIL;
        s_d.good = 1'b0;
        s_d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: iorrd_pkg::IORRD_SUP_WAIT_RAIL, cnt: '0, good: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign standby_power_good_n_o = s_q.good;
endmodule
`default_nettype wire

// ==== verif/iorrd_far_model.sv ====
/* Board reset circuit and hub model on the far side.
   Assumes the bench drives power_on_i by non-blocking assignment on the falling
   edge, so it is seen one edge later; outputs move on the falling edge. */
`default_nettype none
module iorrd_far_model #(
  parameter int unsigned OK_DLY = 8,
  parameter int unsigned HUB_DLY = 4
) (
  input wire logic clk_i, // bench clock
  input wire logic power_on_i, // main power and bus clocks running
  input wire logic fwd_ok_i, // forwarded power ok seen by hub
  output logic main_power_ok_o, // to block
  output logic bus_reset_n_o // hub bus reset, low active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ok_cnt = 8'h00;
  logic [7:0] hub_cnt = 8'h00;
  always_ff @(negedge clk_i) begin
    ok_cnt <= !power_on_i ? 8'h00 : (ok_cnt < 8'(OK_DLY)) ? ok_cnt + 8'h01 : ok_cnt;
    hub_cnt <= !fwd_ok_i ? 8'h00 : (hub_cnt < 8'(HUB_DLY)) ? hub_cnt + 8'h01 : hub_cnt;
  end
  assign main_power_ok_o = ok_cnt >= 8'(OK_DLY);
  assign bus_reset_n_o = hub_cnt >= 8'(HUB_DLY);
endmodule
`default_nettype wire

// ==== verif/iorrd_monitor.sv ====
/* Port checker for the riser reset distribution block.
   Assumes it is bound to iorrd_reset_dist, one clock. */
`default_nettype none
module iorrd_monitor #(
  parameter int unsigned STBY_DELAY_CYC = 20,
  parameter int unsigned FANOUT = 11
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic stby_rail_near_thresh_i,
  input wire logic main_power_ok_i,
  input wire logic pci_bus_reset_low_i,
  input wire logic logic_reprogram_reset_low_i,
  input wire logic video_reset_req_i,
  input wire logic standby_power_good_n_o,
  input wire logic hub_resume_reset_n_o,
  input wire logic mgmt_core_reset_n_o,
  input wire logic main_power_ok_o,
  input wire logic video_reset_n_o,
  input wire logic super_io_reset_n_o,
  input wire logic mgmt_lpc_reset_n_o,
  input wire logic firmware_hub_reset_n_o,
  input wire logic ethernet_reset_n_o,
  input wire logic [FANOUT-1:0] pci_reset_copy_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_pok_forward: assert property (
    main_power_ok_i && standby_power_good_n_o && logic_reprogram_reset_low_i
    |=> main_power_ok_o) else $error("power ok not forwarded");
  a_pok_drop: assert property (
    !main_power_ok_i |=> !main_power_ok_o) else $error("power ok stuck");
  a_fan_low: assert property (
    !pci_bus_reset_low_i |=> !super_io_reset_n_o && !mgmt_lpc_reset_n_o
    && !firmware_hub_reset_n_o && pci_reset_copy_n_o == '0) else $error("copy missed");
  a_fan_high: assert property (
    pci_bus_reset_low_i && standby_power_good_n_o && logic_reprogram_reset_low_i
    |=> super_io_reset_n_o && (&pci_reset_copy_n_o)) else $error("copy stuck");
  a_video_req: assert property (
    video_reset_req_i |=> !video_reset_n_o) else $error("video request ignored");
  a_stby_only: assert property (
    hub_resume_reset_n_o == standby_power_good_n_o
    && mgmt_core_reset_n_o == standby_power_good_n_o) else $error("core reset mixed");
  a_eth_stby: assert property (
    !standby_power_good_n_o |-> !ethernet_reset_n_o) else $error("ethernet free");
  a_reprog_hold: assert property (
    !logic_reprogram_reset_low_i |=> !main_power_ok_o && !video_reset_n_o)
    else $error("reprogram ignored");
  a_rail_drop: assert property (
    !stby_rail_near_thresh_i |=> !standby_power_good_n_o) else $error("good on low rail");
  a_good_delay: assert property (
    $rose(standby_power_good_n_o) |-> $past(stby_rail_near_thresh_i, STBY_DELAY_CYC + 1))
    else $error("good released early");
endmodule
bind iorrd_reset_dist iorrd_monitor #(.STBY_DELAY_CYC(STBY_DELAY_CYC), .FANOUT(FANOUT)) mon (
  .ref_clk_i, .rst_n_i, .stby_rail_near_thresh_i, .main_power_ok_i, .pci_bus_reset_low_i,
  .logic_reprogram_reset_low_i, .video_reset_req_i, .standby_power_good_n_o,
  .hub_resume_reset_n_o, .mgmt_core_reset_n_o, .main_power_ok_o, .video_reset_n_o,
  .super_io_reset_n_o, .mgmt_lpc_reset_n_o, .firmware_hub_reset_n_o, .ethernet_reset_n_o,
  .pci_reset_copy_n_o);
`default_nettype wire

// ==== verif/tb_top.sv ====
/* Self-checking bench for the riser reset distribution block.
   Assumes the far-side model; delay shortened to 20 cycles. */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned D = 20;
  logic ref_clk_i = 0, rst_n_i = 0, stby_rail_near_thresh_i = 0, pwr_on = 0;
  logic logic_reprogram_reset_low_i = 1, video_reset_req_i = 0;
  logic main_power_ok_i, pci_bus_reset_low_i, standby_power_good_n_o, hub_resume_reset_n_o;
  logic mgmt_core_reset_n_o, main_power_ok_o, video_reset_n_o, super_io_reset_n_o;
  logic mgmt_lpc_reset_n_o, firmware_hub_reset_n_o, ethernet_reset_n_o;
  logic [10:0] pci_reset_copy_n_o;
  int err_total = 0;
  int checks_done = 0;
  iorrd_reset_dist #(.STBY_DELAY_CYC(D)) uut (.ref_clk_i, .rst_n_i, .stby_rail_near_thresh_i,
    .main_power_ok_i, .pci_bus_reset_low_i, .logic_reprogram_reset_low_i, .video_reset_req_i,
    .standby_power_good_n_o, .hub_resume_reset_n_o, .mgmt_core_reset_n_o, .main_power_ok_o,
    .video_reset_n_o, .super_io_reset_n_o, .mgmt_lpc_reset_n_o, .firmware_hub_reset_n_o,
    .ethernet_reset_n_o, .pci_reset_copy_n_o);
  iorrd_far_model far (.clk_i(ref_clk_i), .power_on_i(pwr_on), .fwd_ok_i(main_power_ok_o),
    .main_power_ok_o(main_power_ok_i), .bus_reset_n_o(pci_bus_reset_low_i));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic e, input logic a);
    checks_done++;
    if (a !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_stby;
    stby_rail_near_thresh_i = 1;
    cyc(D);
    chk(0, standby_power_good_n_o);
    chk(0, ethernet_reset_n_o);
    cyc(1);
    chk(1, standby_power_good_n_o);
    chk(1, hub_resume_reset_n_o & mgmt_core_reset_n_o);
  endtask
  task automatic t_power_up;
    pwr_on <= 1'b1;
    cyc(10);
    chk(1, main_power_ok_o);
    chk(0, |pci_reset_copy_n_o | super_io_reset_n_o | firmware_hub_reset_n_o);
    cyc(10);
    chk(1, &pci_reset_copy_n_o & mgmt_lpc_reset_n_o & super_io_reset_n_o);
    chk(1, ethernet_reset_n_o & video_reset_n_o & hub_resume_reset_n_o);
  endtask
  task automatic t_video;
    video_reset_req_i = 1;
    cyc(1);
    chk(0, video_reset_n_o);
    chk(1, super_io_reset_n_o);
    video_reset_req_i = 0;
    cyc(1);
    chk(1, video_reset_n_o);
  endtask
  task automatic t_reprog;
    logic_reprogram_reset_low_i = 0;
    cyc(1);
    logic_reprogram_reset_low_i = 1;
    chk(0, main_power_ok_o | video_reset_n_o);
    chk(1, mgmt_core_reset_n_o);
    cyc(20);
    chk(1, main_power_ok_o & video_reset_n_o);
  endtask
  task automatic t_power_down;
    pwr_on <= 1'b0;
    cyc(2);
    chk(0, main_power_ok_o);
    cyc(3);
    chk(0, |pci_reset_copy_n_o | ethernet_reset_n_o);
  endtask
  task automatic t_dip;
    stby_rail_near_thresh_i = 0;
    cyc(1);
    chk(0, standby_power_good_n_o | hub_resume_reset_n_o | ethernet_reset_n_o);
  endtask
  task automatic t_restart;
    stby_rail_near_thresh_i = 1;
    cyc(5);
    stby_rail_near_thresh_i = 0;
    cyc(1);
    stby_rail_near_thresh_i = 1;
    chk(0, standby_power_good_n_o);
    cyc(D);
    chk(0, standby_power_good_n_o);
    cyc(1);
    chk(1, standby_power_good_n_o);
    chk(0, ethernet_reset_n_o);
    cyc(1);
    chk(1, ethernet_reset_n_o);
    rst_n_i = 0;
    cyc(1);
    chk(0, standby_power_good_n_o | ethernet_reset_n_o);
    rst_n_i = 1;
    cyc(1);
    chk(0, standby_power_good_n_o);
  endtask
  initial begin
    #20us;
    err_total++;
    final_report();
  end
  initial begin
    cyc(5);
    rst_n_i = 1;
    t_stby();
    t_power_up();
    t_video();
    t_reprog();
    t_power_down();
    t_dip();
    t_restart();
    final_report();
  end
endmodule
`default_nettype wire
